// ===== common/scp_map.vh
`ifndef SCP_MAP_VH
`define SCP_MAP_VH
`define SCP_WORD_BITS     32
`define SCP_CTRL_LSB      0
`define SCP_CTRL_MSB      3
`define SCP_LATCH_COUNT   4
`define SCP_LATCH_RESET   32'h00000000
`define SCP_RB_BITS       16
`define SCP_RB_SEL_LSB    4
`define SCP_RB_SEL_MSB    5
`define SCP_RB_READ_CTRL  4'hF
`endif

// ===== hdl/scp_serial_config_port.v
`timescale 1ns/100ps
`default_nettype none
`include "scp_map.vh"
module scp_serial_config_port #(
  parameter WORD_BITS = `SCP_WORD_BITS,
  parameter RB_BITS   = `SCP_RB_BITS
) (
  input  wire                         clk_in,
  input  wire                         nrst_in,
  input  wire                         chip_enable_in,
  input  wire                         serial_clock_in,
  input  wire                         serial_write_in,
  input  wire                         latch_load_strobe_in,
  output reg                          serial_readback_out,
  input  wire [4*RB_BITS-1:0]         readback_values_in,
  output wire                         power_down_out,
  output wire [4*WORD_BITS-1:0]       latch_words_out,
  output wire [3:0]                   latch_valid_out,
  output wire                         filter_inphase_test_out,
  output wire                         filter_inphase_test_oe_n_out,
  output wire                         filter_quadrature_test_out,
  output wire                         filter_quadrature_test_oe_n_out
);
  wire       ce_s;
  wire       sck_s;
  wire       sdi_s;
  wire       sle_s;
  reg        sck_q;
  reg        sle_q;
  reg [WORD_BITS-1:0] shift_q;
  reg [1:0]  rb_state_q;
  reg [1:0]  rb_state_d;
  reg [RB_BITS-1:0] rb_shift_q;
  reg [RB_BITS-1:0] rb_shift_d;
  reg [RB_BITS-1:0] rb_left_q;
  reg [RB_BITS-1:0] rb_left_d;
  reg        rb_bit_d;
  wire       sck_rise;
  wire       sck_fall;
  wire       sle_rise;
  wire [3:0] ctrl;
  wire [31:0] ctrl_wide;
  wire       rb_load;
  wire [1:0] rb_sel;
  wire       ce_off;

  scp_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in ({chip_enable_in, serial_clock_in,
                serial_write_in, latch_load_strobe_in}),
    .sync_out ({ce_s, sck_s, sdi_s, sle_s})
  );

  assign ce_off   = ~ce_s;
  assign power_down_out = ce_off;
  assign sck_rise = sck_s & ~sck_q;
  assign sck_fall = ~sck_s & sck_q;
  assign sle_rise = sle_s & ~sle_q;
  assign ctrl     = shift_q[`SCP_CTRL_MSB:`SCP_CTRL_LSB];
  assign ctrl_wide = {28'h0000000, ctrl};
  assign rb_load  = sle_rise && (ctrl == `SCP_RB_READ_CTRL);
  assign rb_sel   = shift_q[`SCP_RB_SEL_MSB:`SCP_RB_SEL_LSB];

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck_q <= 1'b0;
      sle_q <= 1'b0;
    end else begin
      sck_q <= sck_s;
      sle_q <= sle_s;
    end
  end

  // shifting is ignored while powered down; host must start a fresh word
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_q <= {WORD_BITS{1'b0}};
    end else if (ce_off) begin
      shift_q <= {WORD_BITS{1'b0}};
    end else if (sck_rise) begin
      shift_q <= {shift_q[WORD_BITS-2:0], sdi_s};
    end
  end

  // a control code of 0..3 selects a latch; other codes leave latches alone
  genvar gi;
  generate
    for (gi = 0; gi < `SCP_LATCH_COUNT; gi = gi + 1) begin : g_latch
      reg [WORD_BITS-1:0] word_q;
      reg                 valid_q;
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          word_q  <= `SCP_LATCH_RESET;
          valid_q <= 1'b0;
        end else if (ce_off) begin
          word_q  <= `SCP_LATCH_RESET;
          valid_q <= 1'b0;
        end else if (sle_rise && (ctrl_wide == gi)) begin
          word_q  <= shift_q;
          valid_q <= 1'b1;
        end
      end
      assign latch_words_out[gi*WORD_BITS +: WORD_BITS] = word_q;
      assign latch_valid_out[gi] = valid_q;
    end
  endgenerate

  // readback: a read-code strobe captures one value, later serial clock
  // rises send it MSB first; the pin goes low on the first rise after the last bit
  localparam [1:0] RB_IDLE  = 2'b00;
  localparam [1:0] RB_SHIFT = 2'b01;
  localparam [1:0] RB_DONE  = 2'b10;

  always @* begin
    rb_state_d = rb_state_q;
    rb_shift_d = rb_shift_q;
    rb_left_d  = rb_left_q;
    rb_bit_d   = serial_readback_out;
    if (rb_load) begin
      rb_state_d = RB_SHIFT;
      rb_shift_d = readback_values_in[rb_sel*RB_BITS +: RB_BITS];
      rb_left_d  = {RB_BITS{1'b1}};
    end else begin
      case (rb_state_q)
        RB_IDLE: begin
          rb_state_d = RB_IDLE;
        end
        RB_SHIFT: begin
          if (sle_rise) begin
            rb_state_d = RB_IDLE;
          end else if (sck_rise) begin
            rb_bit_d   = rb_shift_q[RB_BITS-1];
            rb_shift_d = {rb_shift_q[RB_BITS-2:0], 1'b0};
            rb_left_d  = {rb_left_q[RB_BITS-2:0], 1'b0};
            if (rb_left_q[RB_BITS-2:0] == {(RB_BITS-1){1'b0}}) begin
              rb_state_d = RB_DONE;
            end
          end
        end
        RB_DONE: begin
          // host may clock past the word: nothing stale leaves the pin
          if (sle_rise) begin
            rb_state_d = RB_IDLE;
          end else if (sck_rise) begin
            rb_bit_d = 1'b0;
          end
        end
        default: begin
          rb_state_d = RB_IDLE;
        end
      endcase
    end
  end

  // power-down wipes a half-sent readback as well
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rb_state_q          <= RB_IDLE;
      rb_shift_q          <= {RB_BITS{1'b0}};
      rb_left_q           <= {RB_BITS{1'b0}};
      serial_readback_out <= 1'b0;
    end else if (ce_off) begin
      rb_state_q          <= RB_IDLE;
      rb_shift_q          <= {RB_BITS{1'b0}};
      rb_left_q           <= {RB_BITS{1'b0}};
      serial_readback_out <= 1'b0;
    end else begin
      rb_state_q          <= rb_state_d;
      rb_shift_q          <= rb_shift_d;
      rb_left_q           <= rb_left_d;
      serial_readback_out <= rb_bit_d;
    end
  end

  // test pins never driven: enable stays inactive (high)
  assign filter_inphase_test_out         = 1'b0;
  assign filter_inphase_test_oe_n_out    = 1'b1;
  assign filter_quadrature_test_out      = 1'b0;
  assign filter_quadrature_test_oe_n_out = 1'b1;
endmodule
`default_nettype wire

// ===== hdl/scp_sync.v
`timescale 1ns/100ps
`default_nettype none
// two-flop level synchroniser, two stages per bit
module scp_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_in,
  input  wire             nrst_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== verification/scp_host.sv
`timescale 1ns/100ps
`default_nettype none
module scp_host (
  input  wire logic clk_in,
  input  wire logic rb_in,
  output var  logic sclk_out,
  output var  logic sdat_out,
  output var  logic strb_out
);
  initial begin
    sclk_out = 1'b0;
    sdat_out = 1'b0;
    strb_out = 1'b0;
  end
  task send(input [31:0] w, input ld);
    for (int i = 31; i >= 0; i--) begin
      sdat_out <= w[i];
      repeat (4) @(posedge clk_in) sclk_out <= 0;
      repeat (4) @(posedge clk_in) sclk_out <= 1;
    end
    repeat (4) @(posedge clk_in) sclk_out <= 0;
    sdat_out <= ~w[0]; // idle line must not echo the last bit
    repeat (8) @(posedge clk_in) strb_out <= ld;
    repeat (8) @(posedge clk_in) strb_out <= 0;
  endtask
  task recv(output [15:0] v);
    for (int i = 0; i < 16; i++) begin
      repeat (4) @(posedge clk_in) sclk_out <= 1;
      repeat (4) @(posedge clk_in) sclk_out <= 0;
      // bit left the device 3 clocks after the rise; taken late in the low
      v = {v[14:0], rb_in};
    end
  endtask
endmodule
`default_nettype wire

// ===== verification/scp_props.sv
`timescale 1ns/100ps
`default_nettype none
module scp_props (
  input wire logic         clk_in,
  input wire logic         nrst_in,
  input wire logic         chip_enable_in,
  input wire logic         latch_load_strobe_in,
  input wire logic         power_down_out,
  input wire logic         serial_readback_out,
  input wire logic         filter_inphase_test_oe_n_out,
  input wire logic         filter_quadrature_test_oe_n_out,
  input wire logic [127:0] latch_words_out,
  input wire logic [3:0]   latch_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_no_load; !latch_load_strobe_in[*8]; endsequence
  sequence s_ce_low; !chip_enable_in[*4]; endsequence
  property p_off; s_ce_low |-> power_down_out; endproperty
  a_off: assert property (p_off) else $error("no power-down");
  property p_clr; power_down_out[*3] |-> latch_valid_out == 0; endproperty
  a_clr: assert property (p_clr) else $error("latch kept");
  property p_hiz; filter_inphase_test_oe_n_out &&
    filter_quadrature_test_oe_n_out; endproperty
  a_hiz: assert property (p_hiz) else $error("test pin driven");
  property p_load; $changed(latch_valid_out) && !power_down_out
    |-> latch_load_strobe_in; endproperty
  a_load: assert property (p_load) else $error("load, no strobe");
  property p_keep; s_no_load
    |-> $stable(latch_words_out) || power_down_out; endproperty
  a_keep: assert property (p_keep) else $error("latch drift");
  property p_wipe; power_down_out |=> latch_words_out == 128'h0
    && latch_valid_out == 4'h0; endproperty
  a_wipe: assert property (p_wipe) else $error("latch not wiped");
  property p_rb_off; power_down_out |=> !serial_readback_out; endproperty
  a_rb_off: assert property (p_rb_off) else $error("readback live");
endmodule
bind scp_serial_config_port scp_props chk (
  .clk_in                          (clk_in),
  .nrst_in                         (nrst_in),
  .chip_enable_in                  (chip_enable_in),
  .latch_load_strobe_in            (latch_load_strobe_in),
  .power_down_out                  (power_down_out),
  .serial_readback_out             (serial_readback_out),
  .filter_inphase_test_oe_n_out    (filter_inphase_test_oe_n_out),
  .filter_quadrature_test_oe_n_out (filter_quadrature_test_oe_n_out),
  .latch_words_out                 (latch_words_out),
  .latch_valid_out                 (latch_valid_out)
);
`default_nettype wire

// ===== verification/scp_serial_config_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module scp_serial_config_port_tb;
  logic clk_in = 0, nrst_in = 0, chip_enable_in = 1;
  logic serial_clock_in, serial_write_in, latch_load_strobe_in;
  logic serial_readback_out, power_down_out;
  logic filter_inphase_test_out, filter_inphase_test_oe_n_out;
  logic filter_quadrature_test_out, filter_quadrature_test_oe_n_out;
  logic [127:0] latch_words_out;
  logic [3:0] latch_valid_out;
  logic [15:0] v;
  wire [63:0] readback_values_in = 64'hA1B2C3D4E5F61788;
  integer n_errors = 0, n_tests = 0, cyc = 0;
  initial forever #5 clk_in = ~clk_in;
  scp_host host (.clk_in, .rb_in(serial_readback_out),
    .sclk_out(serial_clock_in), .sdat_out(serial_write_in),
    .strb_out(latch_load_strobe_in));
  scp_serial_config_port dut (.*);
  task chk(input [127:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %h %h", $time, g, e);
    end
  endtask
  task summarize;
    $display("errors %0d of %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task t_load;
    for (int i = 0; i < 4; i++) host.send({i[3:0], 24'hC3A5F1, i[3:0]}, 1);
    host.send(32'hFFFFFFF7, 1);
    host.send(0, 0);
    for (int i = 0; i < 4; i++)
      chk(latch_words_out[32*i+:32], {i[3:0], 24'hC3A5F1, i[3:0]});
    chk(latch_valid_out, 4'hF);
    chk({filter_inphase_test_oe_n_out, filter_quadrature_test_oe_n_out,
      filter_inphase_test_out, filter_quadrature_test_out}, 4'hC);
  endtask
  task t_rb;
    for (int s = 0; s < 4; s++) begin
      host.send({26'h0, s[1:0], 4'hF}, 1);
      host.recv(v);
      chk(v, readback_values_in[16*s+:16]);
    end
  endtask
  task t_pd;
    chip_enable_in <= 0;
    repeat (9) @(posedge clk_in);
    chip_enable_in <= 1;
    #1 chk(power_down_out, 1);
    chk(latch_valid_out, 0);
    repeat (6) @(posedge clk_in);
    chk(power_down_out, 0);
    chk(latch_words_out, 0);
    for (int i = 0; i < 4; i++)
      host.send({28'h13579BD, i[3:0]}, 1);
    for (int i = 0; i < 4; i++)
      chk(latch_words_out[32*i+:32], {28'h13579BD, i[3:0]});
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1;
    repeat (4) @(posedge clk_in);
    t_load;
    t_rb;
    t_pd;
    summarize;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      summarize;
    end
  end
endmodule
`default_nettype wire
